// >>> bio_pkg.sv
package bio_pkg;

  // ****************************************************************
  // Port geometry
  // ****************************************************************
  localparam int BIO_PORT_W = 8;   // Lines per bidirectional port
  localparam int BIO_FIX_W = 4;    // Lines of the fixed input port
  localparam int BIO_DATA_W = 32;  // APB data width
  localparam int BIO_ADDR_W = 12;  // APB address width

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [11:0] BIO_OFS_FIRST_DATA = 12'h000;   // First port data latch
  localparam logic [11:0] BIO_OFS_SECOND_DATA = 12'h004;  // Second port data latch
  localparam logic [11:0] BIO_OFS_FIXED_DATA = 12'h008;   // Fixed input port
  localparam logic [11:0] BIO_OFS_FIRST_DIR = 12'h00C;    // First port direction
  localparam logic [11:0] BIO_OFS_SECOND_DIR = 12'h010;   // Second port direction

  // ****************************************************************
  // Reset values and fill patterns
  // ****************************************************************
  localparam logic [7:0] BIO_DIR_RST = 8'h00;    // All lines input after reset
  localparam logic [7:0] BIO_LATCH_INIT = 8'h00; // Power-up latch value
  localparam logic [3:0] BIO_FIX_UPPER = 4'hF;   // Upper nibble of fixed port read
  localparam logic [31:0] BIO_RD_ZERO = 32'h0000_0000; // Idle or unmapped read data

  // Register selector for decoded accesses
  typedef enum logic [2:0] {
    BIO_SEL_NONE,
    BIO_SEL_FIRST_DATA,
    BIO_SEL_SECOND_DATA,
    BIO_SEL_FIXED_DATA,
    BIO_SEL_FIRST_DIR,
    BIO_SEL_SECOND_DIR
  } bio_sel_t;

endpackage

// >>> bio_sync.sv
`timescale 1ns/1ns
`default_nettype none
module bio_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw pin levels
  input wire logic [WIDTH-1:0] raw_in,
  // Filtered level
  output logic [WIDTH-1:0] level_out
);
  // ****************************************************************
  // Three-stage synchroniser with agreement filter
  // ****************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] s1;   // First stage, read only by s2
    logic [WIDTH-1:0] s2;   // Second stage
    logic [WIDTH-1:0] s3;   // Third stage
    logic [WIDTH-1:0] lvl;  // Accepted level
  } bio_sync_st_t;

  bio_sync_st_t st_reg;
  bio_sync_st_t st_next;

  // Next state: level moves once stages two and three agree
  always_comb begin
    st_next = st_reg;
    st_next.s1 = raw_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st_reg.s2[i] == st_reg.s3[i]) begin
        st_next.lvl[i] = st_reg.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.lvl;
endmodule
`default_nettype wire

// >>> bio_line_port.sv
`timescale 1ns/1ns
`default_nettype none
module bio_line_port #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write strobes from decode
  input wire logic wr_data,
  input wire logic wr_dir,
  input wire logic [WIDTH-1:0] wdata,
  // Synchronised pin levels
  input wire logic [WIDTH-1:0] pin_level,
  // Stored state and read view
  output logic [WIDTH-1:0] latch_q,
  output logic [WIDTH-1:0] dir_q,
  output logic [WIDTH-1:0] rd_view
);
  import bio_pkg::*;

  // ****************************************************************
  // One bidirectional port: latch and direction
  // ****************************************************************
  typedef struct packed {
    logic [WIDTH-1:0] latch;  // Output data latch
    logic [WIDTH-1:0] dir;    // Direction, 1 = output
  } bio_lp_st_t;

  bio_lp_st_t st_reg;
  bio_lp_st_t st_next;
  logic latch_init_done = 1'b0; // Latch starts defined once, never reset again

  // Next state from write strobes
  always_comb begin
    st_next = st_reg;
    if (wr_data) begin
      st_next.latch = wdata; // R6 R7
    end
    if (wr_dir) begin
      st_next.dir = wdata; // R1
    end
  end

  // Direction cleared by reset, latch kept across it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg.dir <= WIDTH'(BIO_DIR_RST); // R4
    end else begin
      st_reg.dir <= st_next.dir;
    end
    if (!latch_init_done) begin
      st_reg.latch <= WIDTH'(BIO_LATCH_INIT);
    end else begin
      st_reg.latch <= st_next.latch; // R12
    end
  end

  // Power-up marker for the latch, not touched by reset
  always_ff @(posedge clk) begin
    latch_init_done <= 1'b1;
  end

  // Read view: latch on outputs, pin on inputs
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      rd_view[i] = st_reg.dir[i] ? st_reg.latch[i] : pin_level[i]; // R8 R9
    end
  end

  assign latch_q = st_reg.latch;
  assign dir_q = st_reg.dir;
endmodule
`default_nettype wire

// >>> bio_ports.sv
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// R1 - Two eight-line ports, per-line direction bits
// R2 - Direction one drives the line out
// R3 - Direction zero leaves line high-impedance input
// R4 - Reset clears all direction bits
// R5 - Output lines show their latch bit
// R6 - Write with input direction updates latch only
// R7 - Write with output direction updates latch, pin
// R8 - Read returns pin level on inputs
// R9 - Read returns latch on output lines
// R10 - Four-line input port without direction or drive
// R11 - Fixed port read: pins low, ones high
// R12 - Reset keeps data latches unchanged
// R13 - Separate data and direction bus locations
module bio_ports (
  // ****************************************************************
  // Clock and reset
  // ****************************************************************
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // ****************************************************************
  // APB slave
  // ****************************************************************
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [bio_pkg::BIO_ADDR_W-1:0] PADDR,
  input wire logic [bio_pkg::BIO_DATA_W-1:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [bio_pkg::BIO_DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // ****************************************************************
  // First bidirectional port pins
  // ****************************************************************
  input wire logic [bio_pkg::BIO_PORT_W-1:0] FIRST_BIDIR_PORT_LINES_IN,
  output logic [bio_pkg::BIO_PORT_W-1:0] FIRST_BIDIR_PORT_LINES_OUT,
  output logic [bio_pkg::BIO_PORT_W-1:0] FIRST_BIDIR_PORT_LINES_OE_N,
  // ****************************************************************
  // Second bidirectional port pins
  // ****************************************************************
  input wire logic [bio_pkg::BIO_PORT_W-1:0] SECOND_BIDIR_PORT_LINES_IN,
  output logic [bio_pkg::BIO_PORT_W-1:0] SECOND_BIDIR_PORT_LINES_OUT,
  output logic [bio_pkg::BIO_PORT_W-1:0] SECOND_BIDIR_PORT_LINES_OE_N,
  // ****************************************************************
  // Fixed input port pins
  // ****************************************************************
  input wire logic [bio_pkg::BIO_FIX_W-1:0] FIXED_INPUT_PORT_LINES
);
  import bio_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [BIO_DATA_W-1:0] prdata;   // Registered read data
    logic pready;                    // Access-phase answer
    logic pslverr;                   // Unmapped address flag
    logic [BIO_PORT_W-1:0] a_out;    // First port pin drive
    logic [BIO_PORT_W-1:0] a_oe_n;   // First port enable, low = driving
    logic [BIO_PORT_W-1:0] b_out;    // Second port pin drive
    logic [BIO_PORT_W-1:0] b_oe_n;   // Second port enable, low = driving
  } bio_top_st_t;

  bio_top_st_t st_reg;
  bio_top_st_t st_next;

  logic [BIO_PORT_W-1:0] a_pin;      // Filtered first port pins
  logic [BIO_PORT_W-1:0] b_pin;      // Filtered second port pins
  logic [BIO_FIX_W-1:0] c_pin;       // Filtered fixed port pins
  logic [BIO_PORT_W-1:0] a_latch;    // First port latch
  logic [BIO_PORT_W-1:0] a_dir;      // First port direction
  logic [BIO_PORT_W-1:0] a_view;     // First port read view
  logic [BIO_PORT_W-1:0] b_latch;    // Second port latch
  logic [BIO_PORT_W-1:0] b_dir;      // Second port direction
  logic [BIO_PORT_W-1:0] b_view;     // Second port read view
  bio_sel_t sel;                     // Decoded register
  logic setup_ph;                    // APB setup phase
  logic wr_go;                       // Write accepted this edge
  logic lane0;                       // Low byte lane enabled
  logic wr_a_data;                   // First latch write strobe
  logic wr_a_dir;                    // First direction write strobe
  logic wr_b_data;                   // Second latch write strobe
  logic wr_b_dir;                    // Second direction write strobe

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic bio_sel_t bio_decode(input logic [BIO_ADDR_W-1:0] addr);
    if (addr == BIO_OFS_FIRST_DATA) begin
      return BIO_SEL_FIRST_DATA; // R13
    end else if (addr == BIO_OFS_SECOND_DATA) begin
      return BIO_SEL_SECOND_DATA;
    end else if (addr == BIO_OFS_FIXED_DATA) begin
      return BIO_SEL_FIXED_DATA;
    end else if (addr == BIO_OFS_FIRST_DIR) begin
      return BIO_SEL_FIRST_DIR; // R13
    end else if (addr == BIO_OFS_SECOND_DIR) begin
      return BIO_SEL_SECOND_DIR;
    end else begin
      return BIO_SEL_NONE;
    end
  endfunction

  // Decode and write strobes, taken at the edge that ends the access
  always_comb begin
    sel = bio_decode(PADDR);
    setup_ph = PSEL && !PENABLE;
    // Only the low byte lane carries port data
    lane0 = PSTRB[0];
    wr_go = PSEL && PENABLE && st_reg.pready && PWRITE && lane0;
    wr_a_data = wr_go && (sel == BIO_SEL_FIRST_DATA);
    wr_a_dir = wr_go && (sel == BIO_SEL_FIRST_DIR);
    wr_b_data = wr_go && (sel == BIO_SEL_SECOND_DATA);
    wr_b_dir = wr_go && (sel == BIO_SEL_SECOND_DIR);
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  bio_sync #(.WIDTH(BIO_PORT_W)) u_sync_a (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .raw_in(FIRST_BIDIR_PORT_LINES_IN),
    .level_out(a_pin)
  );

  bio_sync #(.WIDTH(BIO_PORT_W)) u_sync_b (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .raw_in(SECOND_BIDIR_PORT_LINES_IN),
    .level_out(b_pin)
  );

  // Fixed port has no drive path at all
  bio_sync #(.WIDTH(BIO_FIX_W)) u_sync_c (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .raw_in(FIXED_INPUT_PORT_LINES),
    .level_out(c_pin)
  ); // R10

  // ****************************************************************
  // Bidirectional ports
  // ****************************************************************
  bio_line_port #(.WIDTH(BIO_PORT_W)) u_port_a (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .wr_data(wr_a_data),
    .wr_dir(wr_a_dir),
    .wdata(PWDATA[BIO_PORT_W-1:0]),
    .pin_level(a_pin),
    .latch_q(a_latch),
    .dir_q(a_dir),
    .rd_view(a_view)
  ); // R1

  bio_line_port #(.WIDTH(BIO_PORT_W)) u_port_b (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .wr_data(wr_b_data),
    .wr_dir(wr_b_dir),
    .wdata(PWDATA[BIO_PORT_W-1:0]),
    .pin_level(b_pin),
    .latch_q(b_latch),
    .dir_q(b_dir),
    .rd_view(b_view)
  ); // R1

  // ****************************************************************
  // Bus answer and pin drive
  // ****************************************************************
  // Next state: no wait state, read data prepared in setup
  always_comb begin
    st_next = st_reg;
    st_next.pready = setup_ph;
    if (setup_ph) begin
      st_next.pslverr = (sel == BIO_SEL_NONE);
      st_next.prdata = BIO_RD_ZERO;
      if (!PWRITE) begin
        if (sel == BIO_SEL_FIRST_DATA) begin
          st_next.prdata[BIO_PORT_W-1:0] = a_view; // R8 R9
        end else if (sel == BIO_SEL_SECOND_DATA) begin
          st_next.prdata[BIO_PORT_W-1:0] = b_view; // R8 R9
        end else if (sel == BIO_SEL_FIXED_DATA) begin
          st_next.prdata[BIO_PORT_W-1:0] = {BIO_FIX_UPPER, c_pin}; // R11
        end else if (sel == BIO_SEL_FIRST_DIR) begin
          st_next.prdata[BIO_PORT_W-1:0] = a_dir;
        end else if (sel == BIO_SEL_SECOND_DIR) begin
          st_next.prdata[BIO_PORT_W-1:0] = b_dir;
        end
      end
    end else begin
      // Answer fields stand for the access cycle only, then clear
      // Keeps stale read data and error off the bus between transfers
      st_next.pslverr = 1'b0;
      st_next.prdata = BIO_RD_ZERO;
    end
    // Pin drive follows latch and direction
    st_next.a_out = a_latch; // R5
    st_next.b_out = b_latch; // R5
    st_next.a_oe_n = ~a_dir; // R2 R3
    st_next.b_oe_n = ~b_dir; // R2 R3
  end

  // State register; reset releases every pin
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      st_reg.prdata <= BIO_RD_ZERO;
      st_reg.pready <= 1'b0;
      st_reg.pslverr <= 1'b0;
      st_reg.a_out <= '0;
      st_reg.b_out <= '0;
      st_reg.a_oe_n <= '1; // R4
      st_reg.b_oe_n <= '1; // R4
    end else begin
      st_reg <= st_next;
    end
  end

  assign PRDATA = st_reg.prdata;
  assign PREADY = st_reg.pready;
  assign PSLVERR = st_reg.pslverr;
  assign FIRST_BIDIR_PORT_LINES_OUT = st_reg.a_out;
  assign FIRST_BIDIR_PORT_LINES_OE_N = st_reg.a_oe_n;
  assign SECOND_BIDIR_PORT_LINES_OUT = st_reg.b_out;
  assign SECOND_BIDIR_PORT_LINES_OE_N = st_reg.b_oe_n;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Helper: high from the second clock on, once the latch load is done
  logic latch_seen = 1'b0;
  always_ff @(posedge CORE_CLK) begin
    latch_seen <= 1'b1;
  end

  // Setup cycle of any transfer
  sequence s_setup;
    PSEL && !PENABLE;
  endsequence

  // Slave answer in the access cycle
  sequence s_answer;
    PREADY;
  endsequence

  // One wait-free access cycle after every setup
  a_answer_timing: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R13
    s_setup |=> s_answer) else $error("no answer one cycle after setup");

  // Answer stands for a single cycle
  a_answer_once: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R13
    s_answer |=> !PREADY) else $error("answer held past one cycle");

  // Bit 0 of the first port drives when set to output
  a_drive_on_out: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R2
    $past(RESETN) && $past(a_dir[0]) |-> !FIRST_BIDIR_PORT_LINES_OE_N[0])
    else $error("output line not driven");

  // Bit 0 of the second port floats when set to input
  a_float_on_in: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R3
    $past(RESETN) && !$past(b_dir[0]) |-> SECOND_BIDIR_PORT_LINES_OE_N[0])
    else $error("input line driven");

  // Whole first port: enables are the inverse of the directions
  a_first_enables: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R2 R3
    $past(RESETN) |-> FIRST_BIDIR_PORT_LINES_OE_N == ~$past(a_dir))
    else $error("first port enables differ from directions");

  // Whole second port likewise
  a_second_enables: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R2 R3
    $past(RESETN) |-> SECOND_BIDIR_PORT_LINES_OE_N == ~$past(b_dir))
    else $error("second port enables differ from directions");

  // Directions read as zero right after reset
  a_reset_dir: assert property (@(posedge CORE_CLK) // R4
    !$past(RESETN) |-> (a_dir == '0) && (b_dir == '0)) else $error("direction not cleared");

  // First port pins show the first latch
  a_out_value: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R5
    $past(RESETN) |-> FIRST_BIDIR_PORT_LINES_OUT == $past(a_latch))
    else $error("pin drive differs from latch");

  // Second port pins show the second latch
  a_second_out: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R5
    $past(RESETN) |-> SECOND_BIDIR_PORT_LINES_OUT == $past(b_latch))
    else $error("second pin drive differs from latch");

  // A data write lands in the latch
  a_write_latch: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R6
    wr_a_data |=> a_latch == $past(PWDATA[BIO_PORT_W-1:0])) else $error("latch not written");

  // A data write leaves the direction alone
  a_write_keeps_dir: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R7
    wr_b_data |=> $stable(b_dir)) else $error("data write changed direction");

  // A direction write lands in the direction bits
  a_write_dir: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R1
    wr_a_dir |=> a_dir == $past(PWDATA[BIO_PORT_W-1:0])) else $error("direction not written");

  // First port read: latch on outputs, pins on inputs
  a_read_mix: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R9
    s_setup and (sel == BIO_SEL_FIRST_DATA) && !PWRITE |=>
    PRDATA[BIO_PORT_W-1:0] == (($past(a_dir) & $past(a_latch)) | (~$past(a_dir) & $past(a_pin))))
    else $error("port read mixes wrongly");

  // Second port read, same mix
  a_second_mix: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R8 R9
    s_setup and (sel == BIO_SEL_SECOND_DATA) && !PWRITE |=>
    PRDATA[BIO_PORT_W-1:0] == (($past(b_dir) & $past(b_latch)) | (~$past(b_dir) & $past(b_pin))))
    else $error("second port read mixes wrongly");

  // Direction bits read back as stored
  a_dir_read: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R13
    s_setup and (sel == BIO_SEL_FIRST_DIR) && !PWRITE |=>
    PRDATA[BIO_PORT_W-1:0] == $past(a_dir)) else $error("direction read wrong");

  // Fixed port read: pins low, ones high
  a_fixed_read: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R11
    s_setup and (sel == BIO_SEL_FIXED_DATA) && !PWRITE |=>
    PRDATA[BIO_PORT_W-1:0] == {BIO_FIX_UPPER, $past(c_pin)}) else $error("fixed port read wrong");

  // Unmapped place answers with an error and zero data
  a_unmapped_err: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R13
    s_setup and (sel == BIO_SEL_NONE) |=> PSLVERR && (PRDATA == BIO_RD_ZERO))
    else $error("unmapped access not refused");

  // Upper read bits are always zero
  a_upper_zero: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R13
    s_answer |-> PRDATA[BIO_DATA_W-1:BIO_PORT_W] == '0) else $error("upper read bits set");

  // Fixed port or unmapped accesses store nothing
  a_no_store: assert property (@(posedge CORE_CLK) disable iff (!RESETN) // R10 R13
    s_setup and (sel == BIO_SEL_FIXED_DATA || sel == BIO_SEL_NONE) |=> ##1
    $stable(a_latch) && $stable(b_latch) && $stable(a_dir) && $stable(b_dir))
    else $error("write stored at a refused place");

  // Reset leaves the data latch as it was
  a_reset_latch: assert property (@(posedge CORE_CLK) // R12
    $past(latch_seen) && !$past(RESETN) |-> $stable(a_latch)) else $error("reset touched latch");
endmodule
`default_nettype wire

// >>> bio_pin_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// External circuitry on one bidirectional port
// ****************************************************************
module bio_pin_model (
  // Device side of the port
  input wire logic [bio_pkg::BIO_PORT_W-1:0] drv_val,
  input wire logic [bio_pkg::BIO_PORT_W-1:0] drv_oe_n,
  // Stiff far-side source set by the bench
  input wire logic [bio_pkg::BIO_PORT_W-1:0] ext_val,
  input wire logic [bio_pkg::BIO_PORT_W-1:0] ext_en,
  // Resolved wire level back to the device
  output logic [bio_pkg::BIO_PORT_W-1:0] level
);
  import bio_pkg::*;
  // Per-line resolution; a stiff source wins, idle lines are pulled up
  always_comb begin
    for (int i = 0; i < BIO_PORT_W; i++) begin
      if (ext_en[i]) begin
        level[i] = ext_val[i]; // Overpowers even a driven line
      end else if (!drv_oe_n[i]) begin
        level[i] = drv_val[i];
      end else begin
        level[i] = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> bidirectional_io_ports_tb.sv
`timescale 1ns/1ns
`default_nettype none
module bidirectional_io_ports_tb;
  import bio_pkg::*;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic core_clk = 1'b0; // 125 MHz core clock
  logic resetn = 1'b0; // Active-low synchronous reset
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [BIO_ADDR_W-1:0] paddr = '0;
  logic [BIO_DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'hF; // All lanes enabled
  logic [BIO_DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic [BIO_PORT_W-1:0] out_v [2]; // Drive values per port
  logic [BIO_PORT_W-1:0] oe_n [2]; // Enables per port, low drives
  logic [BIO_PORT_W-1:0] lvl [2]; // Resolved wire levels
  logic [BIO_PORT_W-1:0] ext_val [2] = '{8'h00, 8'h00}; // Far-side values
  logic [BIO_PORT_W-1:0] ext_en [2] = '{8'h00, 8'h00}; // Far-side enables
  logic [BIO_FIX_W-1:0] fix_pins = 4'h0; // Fixed input pins
  int n_fail = 0;
  int total_checks = 0;
  // ****************************************************************
  // Clock, design and far side
  // ****************************************************************
  always #4 core_clk = ~core_clk;
  bio_ports dut_u (.CORE_CLK(core_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .FIRST_BIDIR_PORT_LINES_IN(lvl[0]),
    .FIRST_BIDIR_PORT_LINES_OUT(out_v[0]), .FIRST_BIDIR_PORT_LINES_OE_N(oe_n[0]),
    .SECOND_BIDIR_PORT_LINES_IN(lvl[1]), .SECOND_BIDIR_PORT_LINES_OUT(out_v[1]),
    .SECOND_BIDIR_PORT_LINES_OE_N(oe_n[1]), .FIXED_INPUT_PORT_LINES(fix_pins));
  bio_pin_model pm0_u (.drv_val(out_v[0]), .drv_oe_n(oe_n[0]), .ext_val(ext_val[0]),
    .ext_en(ext_en[0]), .level(lvl[0]));
  bio_pin_model pm1_u (.drv_val(out_v[1]), .drv_oe_n(oe_n[1]), .ext_val(ext_val[1]),
    .ext_en(ext_en[1]), .level(lvl[1]));
  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // Wait whole clock cycles
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One APB transfer, waits for pready under a bound
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      $display("wrong value at %0t ns: got %h expected %h", $time, 1'b0, 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Register write expecting no error
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, {24'h000000, d}, rd, err);
    chk({31'h0, err}, 32'h0000_0000);
  endtask
  // Register read against an expected word
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic err;
    apb(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0000_0000);
  endtask
  // Data and direction offsets of a port
  function automatic logic [11:0] dat_a(input int p);
    return (p == 0) ? BIO_OFS_FIRST_DATA : BIO_OFS_SECOND_DATA;
  endfunction
  function automatic logic [11:0] dir_a(input int p);
    return (p == 0) ? BIO_OFS_FIRST_DIR : BIO_OFS_SECOND_DIR;
  endfunction
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // State straight after reset
  task automatic t_reset_state();
    for (int p = 0; p < 2; p++) begin
      chk({24'h0, oe_n[p]}, 32'h0000_00FF);
      rd_chk(dir_a(p), 32'h0000_0000);
    end
    $display("test reset_state done");
  endtask
  // Inputs: writes land in the latch only, reads show the pins
  task automatic t_input_read();
    for (int p = 0; p < 2; p++) begin
      ext_en[p] <= 8'hFF;
      ext_val[p] <= 8'h3C ^ p[7:0];
      wr_reg(dat_a(p), 8'hA5);
      wait_cyc(2);
      chk({24'h0, oe_n[p]}, 32'h0000_00FF);
      wait_cyc(6);
      rd_chk(dat_a(p), {24'h0, 8'h3C ^ p[7:0]});
    end
    $display("test input_read done");
  endtask
  // Mixed directions, far side fighting the outputs
  task automatic t_mixed();
    for (int p = 0; p < 2; p++) begin
      ext_val[p] <= 8'hC3;
      wr_reg(dat_a(p), 8'h5A);
      wr_reg(dir_a(p), 8'h0F);
      wait_cyc(2);
      chk({24'h0, oe_n[p]}, 32'h0000_00F0);
      chk({24'h0, out_v[p]}, 32'h0000_005A);
      wait_cyc(6);
      rd_chk(dat_a(p), 32'h0000_00CA);
      rd_chk(dir_a(p), 32'h0000_000F);
    end
    $display("test mixed done");
  endtask
  // Latches survive a mid-run reset, directions do not
  task automatic t_latch_keep();
    for (int p = 0; p < 2; p++) begin
      ext_en[p] <= 8'h00;
      wr_reg(dat_a(p), 8'h96);
      wr_reg(dir_a(p), 8'hFF);
    end
    resetn <= 1'b0;
    wait_cyc(3);
    resetn <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      chk({24'h0, oe_n[p]}, 32'h0000_00FF);
      rd_chk(dir_a(p), 32'h0000_0000);
      wr_reg(dir_a(p), 8'hFF);
      wait_cyc(2);
      chk({24'h0, out_v[p]}, 32'h0000_0096);
      rd_chk(dat_a(p), 32'h0000_0096);
    end
    $display("test latch_keep done");
  endtask
  // Fixed input port: pins low, ones high, writes change nothing
  task automatic t_fixed();
    logic [3:0] pat [4] = '{4'h0, 4'h6, 4'h9, 4'hF};
    for (int i = 0; i < 4; i++) begin
      fix_pins <= pat[i];
      wait_cyc(6);
      rd_chk(BIO_OFS_FIXED_DATA, {24'h0, BIO_FIX_UPPER, pat[i]});
    end
    wr_reg(BIO_OFS_FIXED_DATA, 8'h00);
    rd_chk(BIO_OFS_FIXED_DATA, 32'h0000_00FF);
    $display("test fixed done");
  endtask
  // Unmapped place answers with an error and stores nothing
  task automatic t_unmapped();
    logic [31:0] rd;
    logic err;
    apb(1'b1, 12'h014, 32'h0000_0000, rd, err);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b0, 12'hFFC, 32'h0000_0000, rd, err);
    chk({err, rd[30:0]}, 32'h8000_0000);
    rd_chk(BIO_OFS_FIRST_DIR, 32'h0000_00FF);
    $display("test unmapped done");
  endtask
  // ****************************************************************
  // Verdict, main sequence and watchdog
  // ****************************************************************
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    wait_cyc(12);
    resetn <= 1'b1;
    wait_cyc(6);
    t_reset_state();
    t_input_read();
    t_mixed();
    t_latch_keep();
    t_fixed();
    t_unmapped();
    give_verdict();
  end
  // Tests need well under 1000 cycles
  initial begin
    wait_cyc(20000);
    n_fail++;
    give_verdict();
  end
endmodule
`default_nettype wire
